// File: spi_port_pkg.sv
// Shared constants and types for the serial register port
`default_nettype none
package spi_port_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h05;
  localparam logic [4:0] COUNT_MAX = 5'h1f;
  localparam logic [4:0] TOP_BIT_INDEX = 5'h0f;
  localparam int RW_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 11;
  localparam int DATA_MSB = 10;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic LINE_RELEASED = 1'b1;

  typedef logic [10:0] reg_data_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [15:0] frame_word_t;

  // ****************************************
  // Register map of the device
  // ****************************************
  localparam int NUM_REGS = 8;
  localparam reg_addr_t ADDR_FAULT_STATUS_PRIMARY = 4'h0;
  localparam reg_addr_t ADDR_FAULT_STATUS_SECONDARY = 4'h1;
  localparam reg_addr_t ADDR_DRIVE_CONFIG = 4'h2;
  localparam reg_addr_t ADDR_HIGH_SIDE_DRIVE_STRENGTH = 4'h3;
  localparam reg_addr_t ADDR_LOW_SIDE_DRIVE_CONFIG = 4'h4;
  localparam reg_addr_t ADDR_OVERCURRENT_CONFIG = 4'h5;
  localparam reg_addr_t ADDR_SENSE_AMP_CONFIG = 4'h6;
  localparam reg_addr_t ADDR_CALIBRATION_SELECT = 4'h7;
  localparam reg_addr_t LAST_ADDR = 4'h7;
  localparam reg_data_t REG_RESET = 11'h000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int CS_GAP_NS = 400;
  localparam int CS_GAP_CYCLES =
    (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Controller registers on APB
  // ****************************************
  localparam logic [11:0] OFS_TX_WORD = 12'h000;
  localparam logic [11:0] OFS_FRAME_LEN = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_RX_WORD = 12'h00c;
  localparam logic [4:0] RESET_FRAME_LEN = 5'h10;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_REFUSED = 1;

  typedef enum logic [2:0] {
    HOST_IDLE = 3'b000,
    HOST_LEAD = 3'b001,
    HOST_HIGH = 3'b011,
    HOST_LOW = 3'b010,
    HOST_TAIL = 3'b110,
    HOST_GAP = 3'b111
  } host_state_t;

endpackage
`default_nettype wire

// File: spi_link_if.sv
// Serial link between controller and register port
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic chip_select_n;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  logic sdo_line;

  // Open-drain line with pull-up
  assign sdo_line = (sdo_oe && !sdo_out) ? 1'b0 : 1'b1;

  modport host (
    output sclk,
    output chip_select_n,
    output sdi,
    input sdo_line
  );

  modport dev (
    input sclk,
    input chip_select_n,
    input sdi,
    output sdo_out,
    output sdo_oe
  );
endinterface
`default_nettype wire

// File: gate_driver_spi_register_port.sv
// Device end: serial slave and register file of the gate driver
//
// Operation
// - Shift every word most significant bit first
// - Master gives exactly sixteen clocks per frame; controller gives frame_len clocks, 16 after reset
// - Wrong bit count flags error, discards word
// - Write returns old register contents after command
// - Serial output only pulls low or releases
// - Bit 15 flag, bits 14-11 address, data below
// - Flag zero writes, flag one reads
// - Output word: five idle bits, eleven data
// - Status registers at 0h and 1h read-only
// - Reserved bits default to zero
// - Master avoids writes beyond defined map
// - Master should set lock against stray writes; no lock here, writes to 2h-7h always taken
// - Clock low at both chip select edges
// - Chip select high 400 ns between words
// - Ignore link and release output when deselected
// - Sample on falling edge, launch on rising
//
// Our own choice: register access over APB.
`default_nettype none
module gate_driver_spi_register_port
  import spi_port_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fault inputs
  input wire logic [10:0] fault_primary_i,
  input wire logic [10:0] fault_secondary_i,
  // Control outputs
  output logic [10:0] drive_config_o,
  output logic [10:0] high_side_drive_strength_o,
  output logic [10:0] low_side_drive_config_o,
  output logic [10:0] overcurrent_config_o,
  output logic [10:0] sense_amp_config_o,
  output logic [10:0] calibration_select_o,
  // Events
  output logic frame_error_o,
  output logic write_strobe_o,
  // Link
  spi_link_if.dev link
);

  // ****************************************
  // Link domain: receive on falling edge
  // ****************************************
  logic [4:0] bit_count;
  logic [4:0] next_bit_count;
  frame_word_t rx_shift;
  frame_word_t next_rx_shift;
  logic open_flag;
  logic next_open_flag;
  logic taken_tog;
  logic next_taken_tog;
  reg_addr_t rd_addr;
  reg_addr_t next_rd_addr;
  logic done_tog;
  logic first_bit;

  assign first_bit = !open_flag || (taken_tog != done_tog);

  always_comb
  begin
    next_bit_count = bit_count;
    next_rx_shift = rx_shift;
    next_open_flag = open_flag;
    next_taken_tog = taken_tog;
    next_rd_addr = rd_addr;
    if (!link.chip_select_n)
    begin
      next_open_flag = 1'b1;
      next_taken_tog = done_tog;
      next_rx_shift = {rx_shift[14:0], link.sdi};
      if (first_bit)
      begin
        next_bit_count = 5'h01;
        next_rx_shift = {15'h0000, link.sdi};
      end
      else if (bit_count != COUNT_MAX)
      begin
        next_bit_count = bit_count + 5'h01;
      end
      if (next_bit_count == CMD_BITS)
      begin
        next_rd_addr = next_rx_shift[3:0];
      end
    end
  end

  always_ff @(negedge link.sclk or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bit_count <= 5'h00;
      rx_shift <= 16'h0000;
      open_flag <= 1'b0;
      taken_tog <= 1'b0;
      rd_addr <= 4'h0;
    end
    else
    begin
      bit_count <= next_bit_count;
      rx_shift <= next_rx_shift;
      open_flag <= next_open_flag;
      taken_tog <= next_taken_tog;
      rd_addr <= next_rd_addr;
    end
  end

  // ****************************************
  // Link domain: transmit on rising edge
  // ****************************************
  reg_data_t snap [NUM_REGS];
  reg_data_t next_snap [NUM_REGS];
  logic sdo_bit;
  logic next_sdo_bit;
  logic [4:0] launch_count;
  logic [3:0] data_index;
  reg_data_t out_data;

  assign launch_count = first_bit ? 5'h00 : bit_count;
  assign data_index = 4'(TOP_BIT_INDEX - launch_count);

  always_comb
  begin
    out_data = REG_RESET;
    if (rd_addr <= LAST_ADDR)
    begin
      out_data = snap[rd_addr[2:0]];
    end
    next_sdo_bit = LINE_RELEASED;
    if (!link.chip_select_n && launch_count >= CMD_BITS &&
        launch_count < FRAME_BITS)
    begin
      next_sdo_bit = out_data[data_index];
    end
  end

  always_ff @(posedge link.sclk or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sdo_bit <= LINE_RELEASED;
    end
    else
    begin
      sdo_bit <= next_sdo_bit;
    end
  end

  assign link.sdo_out = 1'b0;
  assign link.sdo_oe = !link.chip_select_n && !sdo_bit &&
                       launch_count >= CMD_BITS;

  // ****************************************
  // System domain: synchronisers
  // ****************************************
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  reg_data_t fp_meta;
  reg_data_t fp_sync;
  reg_data_t fs_meta;
  reg_data_t fs_sync;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      fp_meta <= REG_RESET;
      fp_sync <= REG_RESET;
      fs_meta <= REG_RESET;
      fs_sync <= REG_RESET;
    end
    else
    begin
      cs_meta <= link.chip_select_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      fp_meta <= fault_primary_i;
      fp_sync <= fp_meta;
      fs_meta <= fault_secondary_i;
      fs_sync <= fs_meta;
    end
  end

  // ****************************************
  // System domain: frame commit and registers
  // ****************************************
  reg_data_t regs [NUM_REGS];
  reg_data_t next_regs [NUM_REGS];
  logic next_done_tog;
  logic next_frame_error;
  logic next_write_strobe;
  logic cs_rise;
  logic [4:0] frame_bits;
  reg_addr_t wr_addr;

  assign cs_rise = cs_sync && !cs_prev;
  assign frame_bits = (open_flag && taken_tog == done_tog) ? bit_count : 5'h00;
  assign wr_addr = rx_shift[ADDR_MSB:ADDR_LSB];

  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      next_regs[i] = regs[i];
      next_snap[i] = snap[i];
      if (cs_sync)
      begin
        next_snap[i] = regs[i];
      end
    end
    next_regs[ADDR_FAULT_STATUS_PRIMARY[2:0]] = fp_sync;
    next_regs[ADDR_FAULT_STATUS_SECONDARY[2:0]] = fs_sync;
    next_done_tog = done_tog;
    next_frame_error = 1'b0;
    next_write_strobe = 1'b0;
    if (cs_rise)
    begin
      next_done_tog = done_tog ^ (frame_bits != 5'h00);
      if (frame_bits != FRAME_BITS)
      begin
        next_frame_error = 1'b1;
      end
      else if (rx_shift[RW_POS] == RW_WRITE &&
               wr_addr >= ADDR_DRIVE_CONFIG && wr_addr <= LAST_ADDR)
      begin
        next_regs[wr_addr[2:0]] = rx_shift[DATA_MSB:0];
        next_write_strobe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs[i] <= REG_RESET;
        snap[i] <= REG_RESET;
      end
      done_tog <= 1'b0;
      frame_error_o <= 1'b0;
      write_strobe_o <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs[i] <= next_regs[i];
        snap[i] <= next_snap[i];
      end
      done_tog <= next_done_tog;
      frame_error_o <= next_frame_error;
      write_strobe_o <= next_write_strobe;
    end
  end

  assign drive_config_o = regs[ADDR_DRIVE_CONFIG[2:0]];
  assign high_side_drive_strength_o = regs[ADDR_HIGH_SIDE_DRIVE_STRENGTH[2:0]];
  assign low_side_drive_config_o = regs[ADDR_LOW_SIDE_DRIVE_CONFIG[2:0]];
  assign overcurrent_config_o = regs[ADDR_OVERCURRENT_CONFIG[2:0]];
  assign sense_amp_config_o = regs[ADDR_SENSE_AMP_CONFIG[2:0]];
  assign calibration_select_o = regs[ADDR_CALIBRATION_SELECT[2:0]];

endmodule
`default_nettype wire

// File: gate_driver_spi_controller.sv
// Controller end: APB-driven serial master for the register port
`default_nettype none
module gate_driver_spi_controller
  import spi_port_pkg::*;
#(
  parameter int HALF_CYCLES = 4
)
(
  // System
  input wire logic clk_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Link
  spi_link_if.host link
);

  // ****************************************
  // APB decode
  // ****************************************
  logic access;
  logic mapped;
  logic wr_tx;
  logic refuse;
  host_state_t state;
  host_state_t next_state;
  frame_word_t tx_word;
  frame_word_t rx_word;
  logic [4:0] frame_len;
  logic refused;
  logic [31:0] next_prdata;

  assign access = psel_i && penable_i;
  assign mapped = paddr_i == OFS_TX_WORD || paddr_i == OFS_FRAME_LEN ||
                  paddr_i == OFS_STATUS || paddr_i == OFS_RX_WORD;
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign wr_tx = access && pwrite_i && paddr_i == OFS_TX_WORD &&
                 state == HOST_IDLE;
  assign refuse = pwdata_i[RW_POS] == RW_WRITE &&
                  pwdata_i[ADDR_MSB:ADDR_LSB] > LAST_ADDR;

  always_comb
  begin
    next_prdata = prdata_o;
    if (psel_i && !penable_i)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr_i)
        OFS_TX_WORD: next_prdata = {16'h0000, tx_word};
        OFS_FRAME_LEN: next_prdata = {27'h0000000, frame_len};
        OFS_STATUS: next_prdata = {30'h00000000, refused,
                                   state != HOST_IDLE};
        OFS_RX_WORD: next_prdata = {16'h0000, rx_word};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Serial engine
  // ****************************************
  logic sdo_meta;
  logic sdo_sync;
  logic [7:0] wait_count;
  logic [7:0] next_wait_count;
  logic [4:0] bits_done;
  logic [4:0] next_bits_done;
  frame_word_t tx_shift;
  frame_word_t next_tx_shift;
  frame_word_t rx_shift;
  frame_word_t next_rx_shift;
  frame_word_t next_tx_word;
  frame_word_t next_rx_word;
  logic [4:0] next_frame_len;
  logic next_refused;
  logic sclk;
  logic next_sclk;
  logic cs_n;
  logic next_cs_n;
  logic sdi;
  logic next_sdi;
  logic [7:0] half_load;

  assign half_load = 8'(HALF_CYCLES - 1);

  always_comb
  begin
    next_state = state;
    next_wait_count = wait_count;
    next_bits_done = bits_done;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_tx_word = tx_word;
    next_rx_word = rx_word;
    next_frame_len = frame_len;
    next_refused = refused;
    next_sclk = sclk;
    next_cs_n = cs_n;
    next_sdi = sdi;
    if (access && pwrite_i && paddr_i == OFS_FRAME_LEN &&
        state == HOST_IDLE)
    begin
      next_frame_len = pwdata_i[4:0];
    end
    if (wait_count != 8'h00)
    begin
      next_wait_count = wait_count - 8'h01;
    end
    case (state)
      HOST_IDLE:
      begin
        if (wr_tx)
        begin
          next_refused = refuse;
          if (!refuse)
          begin
            next_tx_word = pwdata_i[15:0];
            next_tx_shift = pwdata_i[15:0];
            next_cs_n = 1'b0;
            next_bits_done = 5'h00;
            next_wait_count = half_load;
            next_state = HOST_LEAD;
          end
        end
      end
      HOST_LEAD, HOST_LOW:
      begin
        if (wait_count == 8'h00)
        begin
          next_wait_count = half_load;
          if (state == HOST_LEAD && frame_len == 5'h00)
          begin
            next_state = HOST_TAIL;
          end
          else
          begin
            next_sclk = 1'b1;
            next_sdi = tx_shift[15];
            next_tx_shift = {tx_shift[14:0], 1'b0};
            next_state = HOST_HIGH;
          end
        end
      end
      HOST_HIGH:
      begin
        if (wait_count == 8'h00)
        begin
          next_wait_count = half_load;
          next_sclk = 1'b0;
          next_rx_shift = {rx_shift[14:0], sdo_sync};
          next_bits_done = bits_done + 5'h01;
          next_state = HOST_LOW;
          if (bits_done + 5'h01 == frame_len)
          begin
            next_state = HOST_TAIL;
          end
        end
      end
      HOST_TAIL:
      begin
        if (wait_count == 8'h00)
        begin
          next_cs_n = 1'b1;
          next_rx_word = rx_shift;
          next_wait_count = 8'(CS_GAP_CYCLES - 1);
          next_state = HOST_GAP;
        end
      end
      HOST_GAP:
      begin
        if (wait_count == 8'h00)
        begin
          next_state = HOST_IDLE;
        end
      end
      default:
      begin
        next_state = HOST_IDLE;
        next_cs_n = 1'b1;
        next_sclk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state <= HOST_IDLE;
      wait_count <= 8'h00;
      bits_done <= 5'h00;
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
      tx_word <= 16'h0000;
      rx_word <= 16'h0000;
      frame_len <= RESET_FRAME_LEN;
      refused <= 1'b0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      sdi <= 1'b0;
      sdo_meta <= LINE_RELEASED;
      sdo_sync <= LINE_RELEASED;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      wait_count <= next_wait_count;
      bits_done <= next_bits_done;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      tx_word <= next_tx_word;
      rx_word <= next_rx_word;
      frame_len <= next_frame_len;
      refused <= next_refused;
      sclk <= next_sclk;
      cs_n <= next_cs_n;
      sdi <= next_sdi;
      sdo_meta <= link.sdo_line;
      sdo_sync <= sdo_meta;
      prdata_o <= next_prdata;
    end
  end

  assign link.sclk = sclk;
  assign link.chip_select_n = cs_n;
  assign link.sdi = sdi;

endmodule
`default_nettype wire

// File: gate_driver_spi_chk.sv
// Checker on the serial link between controller and register port
`default_nettype none
module gate_driver_spi_chk
(
  // System
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic next_sclk_q;
  logic [4:0] rises;
  logic [4:0] next_rises;
  logic [4:0] seen;

  // ****************************************
  // Rising serial clock edges in this frame
  // ****************************************
  assign seen = rises + {4'h0, sclk & ~sclk_q};
  always_comb
  begin
    next_sclk_q = resetn_i & sclk;
    next_rises = (!resetn_i || chip_select_n) ? 5'h00 : seen;
  end
  always_ff @(posedge clk_i)
  begin
    sclk_q <= next_sclk_q;
    rises <= next_rises;
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_sclk_low;
    !sclk && !$past(sclk);
  endsequence
  sequence s_gap;
    chip_select_n [*8] ##1 chip_select_n [*8];
  endsequence
  property p_release;
    chip_select_n |-> !sdo_oe;
  endproperty
  property p_drive;
    sdo_oe |-> !sdo_out && !sdo_line;
  endproperty
  property p_quiet;
    !chip_select_n && seen < 5'h06 |-> !sdo_oe;
  endproperty
  property p_launch;
    $changed(sdo_oe) && !chip_select_n && !$past(chip_select_n)
      |-> $rose(sclk);
  endproperty
  property p_sdi;
    $changed(sdi) && !chip_select_n && !$past(chip_select_n)
      |-> $rose(sclk);
  endproperty
  property p_hold;
    sclk && $past(sclk) |-> $stable(sdo_oe) && $stable(sdi);
  endproperty
  property p_cs_fall;
    $fell(chip_select_n) |-> s_sclk_low;
  endproperty
  property p_cs_rise;
    $rose(chip_select_n) |-> s_sclk_low;
  endproperty
  property p_gap;
    $rose(chip_select_n) |-> s_gap;
  endproperty
  a_release: assert property (p_release)
    else $error("output driven while deselected");
  a_drive: assert property (p_drive)
    else $error("output driven high");
  a_quiet: assert property (p_quiet)
    else $error("output driven in command bits");
  a_launch: assert property (p_launch)
    else $error("output changed off rising clock");
  a_sdi: assert property (p_sdi)
    else $error("input data changed off rising clock");
  a_hold: assert property (p_hold)
    else $error("data moved while clock high");
  a_cs_fall: assert property (p_cs_fall)
    else $error("clock high at select fall");
  a_cs_rise: assert property (p_cs_rise)
    else $error("clock high at select rise");
  a_gap: assert property (p_gap)
    else $error("select gap too short");
endmodule
`default_nettype wire

// File: gate_driver_spi_register_port_bench.sv
// Bench for the register port joined to its APB serial controller
`default_nettype none
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("[FAIL] %s expected %h seen %h", what, exp, got); \
  end end
module gate_driver_spi_register_port_bench import spi_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, frame_err, wr_stb;
  logic [10:0] fault_p = 11'h5a5, fault_s = 11'h2c3;
  wire reg_data_t cfg [2:7];
  reg_data_t model [8];
  logic [15:0] mon_in, mon_out;
  logic [4:0] mon_n;
  int n_mismatch = 0, tests_run = 0, cycles = 0, n_ferr = 0, n_wstb = 0;

  always #12.5 clk = ~clk;
  spi_link_if link ();
  gate_driver_spi_controller i_gate_driver_spi_controller (
    .clk_i(clk), .resetn_i(resetn), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link));
  gate_driver_spi_register_port i_gate_driver_spi_register_port (
    .clk_i(clk), .resetn_i(resetn), .fault_primary_i(fault_p),
    .fault_secondary_i(fault_s), .drive_config_o(cfg[2]),
    .high_side_drive_strength_o(cfg[3]), .low_side_drive_config_o(cfg[4]),
    .overcurrent_config_o(cfg[5]), .sense_amp_config_o(cfg[6]),
    .calibration_select_o(cfg[7]), .frame_error_o(frame_err),
    .write_strobe_o(wr_stb), .link(link));
  gate_driver_spi_chk u_chk (.clk_i(clk), .resetn_i(resetn),
    .sclk(link.sclk), .chip_select_n(link.chip_select_n), .sdi(link.sdi),
    .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));

  // ****************************************
  // Wire monitor, pulse counters, timeout
  // ****************************************
  always @(negedge link.sclk)
    if (link.chip_select_n === 1'h0)
    begin
      mon_in <= {mon_in[14:0], link.sdi};
      mon_out <= {mon_out[14:0], link.sdo_line};
      mon_n <= mon_n + 5'h01;
    end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (frame_err === 1'h1) n_ferr <= n_ferr + 1;
    if (wr_stb === 1'h1) n_wstb <= n_wstb + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  // ****************************************
  // Bus and frame tasks
  // ****************************************
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'h1;
    penable <= 1'h0;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic frame(input logic [15:0] w, output logic [15:0] rx);
    logic [31:0] d;
    logic e;
    mon_n = 5'h00;
    apb(OFS_TX_WORD, 1'h1, {16'h0000, w}, d, e);
    repeat (2) @(posedge clk);
    d = 32'h1;
    while (d[STATUS_BUSY] !== 1'h0) apb(OFS_STATUS, 1'h0, 32'h0, d, e);
    apb(OFS_RX_WORD, 1'h0, 32'h0, d, e);
    rx = d[15:0];
  endtask
  task automatic access(input logic rw, input reg_addr_t a,
    input reg_data_t v);
    logic [15:0] rx;
    int s;
    s = n_wstb;
    frame({rw, a, v}, rx);
    `CHK("bit count", FRAME_BITS, mon_n)
    `CHK("word on wire", {rw, a, v}, mon_in)
    `CHK("released bits", 5'h1f, mon_out[15:11])
    `CHK("reply on wire", model[a], mon_out[10:0])
    `CHK("reply word", model[a], rx[10:0])
    if (rw == RW_WRITE && a > 4'h1) model[a] = v;
    `CHK("strobes", int'(rw == RW_WRITE && a > 4'h1), n_wstb - s)
    if (a > 4'h1) `CHK("port", model[a], cfg[a])
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    for (int a = 0; a < 8; a++) access(RW_READ, reg_addr_t'(a), 11'h7ff);
    $display("reset values and read frames done");
  endtask
  task automatic t_write;
    for (int a = 0; a < 8; a++) access(RW_WRITE, reg_addr_t'(a), 11'h7ff);
    for (int a = 0; a < 8; a++)
      access(RW_WRITE, reg_addr_t'(a), 11'h2a5 + 11'(a));
    fault_p <= 11'h3c1;
    model[0] = 11'h3c1;
    repeat (4) @(posedge clk);
    for (int a = 7; a >= 0; a--) access(RW_READ, reg_addr_t'(a), 11'h000);
    $display("write and read back done");
  endtask
  task automatic t_frame_err;
    logic [31:0] d;
    logic e;
    logic [15:0] rx;
    int s;
    int lens [4] = '{0, 0, 15, 17};
    foreach (lens[k])
    begin
      s = n_ferr;
      apb(OFS_FRAME_LEN, 1'h1, 32'(lens[k]), d, e);
      frame({RW_WRITE, ADDR_DRIVE_CONFIG, 11'h13c}, rx);
      `CHK("short or long count", 5'(lens[k]), mon_n)
      `CHK("frame errors", s + 1, n_ferr)
    end
    apb(OFS_FRAME_LEN, 1'h1, 32'h10, d, e);
    access(RW_READ, ADDR_DRIVE_CONFIG, 11'h000);
    $display("frame error done");
  endtask
  task automatic t_refuse;
    logic [31:0] d;
    logic e;
    logic [15:0] rx;
    apb(OFS_TX_WORD, 1'h1, {16'h0, RW_WRITE, 4'h9, 11'h001}, d, e);
    apb(OFS_STATUS, 1'h0, 32'h0, d, e);
    `CHK("refused", 2'h2, d[1:0])
    frame({RW_READ, 4'hc, 11'h000}, rx);
    `CHK("outside map", 11'h000, rx[10:0])
    apb(12'h010, 1'h0, 32'h0, d, e);
    `CHK("bus error", 1'h1, e)
    `CHK("bus data", 32'h0, d)
    $display("refusals done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    model[0] = 11'h5a5;
    model[1] = 11'h2c3;
    for (int a = 2; a < 8; a++) model[a] = REG_RESET;
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(posedge clk);
    t_reset();
    t_write();
    t_frame_err();
    t_refuse();
    report_and_stop();
  end
endmodule
`default_nettype wire
